// *** hw/fpg_consts.svh ***
// fpg_consts.svh: register offsets, field positions, reset values and counts for the front-panel gpio block
// assumes: included by bare name into the package and the top module
`ifndef FPG_CONSTS_SVH
`define FPG_CONSTS_SVH

`define FPG_NUM_AUX          12
`define FPG_OFF_DIR          12'h000
`define FPG_OFF_LEVEL        12'h004
`define FPG_OFF_SAMPLE       12'h008
`define FPG_OFF_CUSTOM_CTRL  12'h00C
`define FPG_OFF_CUSTOM_STAT  12'h010
`define FPG_OFF_ROUTE        12'h014
`define FPG_BIT_EVENT        0
`define FPG_BIT_SYNC         1
`define FPG_BIT_AUX0         2
`define FPG_NUM_BITS         14
`define FPG_RST_DIR          32'h0000_0000
`define FPG_RST_LEVEL        32'h0000_0000
`define FPG_RST_CUSTOM       32'h0000_0000
`define FPG_RESP_OKAY        2'h0
`define FPG_RESP_SLVERR      2'h2

`endif

// *** hw/fpg_pkg.sv ***
// fpg_pkg.sv: types shared by the front-panel gpio block
// assumes: fpg_consts.svh on the include path
`include "fpg_consts.svh"
package fpg_pkg;
  // one bit per pin: event pin, sync pin, then the aux connector pins
  typedef logic [`FPG_NUM_BITS-1:0] fpg_pins_t;

  // per-pin bundle toward the connectors
  typedef struct packed {
    fpg_pins_t out;   // driven level
    fpg_pins_t oe;    // output enable, high while driving
  } fpg_drive_t;

  // read channel states of the slave
  typedef enum logic [1:0] {
    FPG_RD_IDLE,
    FPG_RD_RESP
  } fpg_rd_state_t;

  typedef enum logic [1:0] {
    FPG_WR_IDLE,
    FPG_WR_RESP
  } fpg_wr_state_t;
endpackage : fpg_pkg

// *** hw/fpg_front_gpio.sv ***
// fpg_front_gpio.sv: front-panel gpio control with an axi4-lite register slave
// assumes: one 40 MHz clock aclk, synchronous active-low aresetn, pins arrive asynchronous
//
// Overview of operation
// - pin routed to active function, no manual step
// - input sampler runs regardless of direction
// - driver on only when direction is output
// - reading an output pin returns driven level
// - trigger logic always sees the event pin
// - sync pin behaves like event pin normally
// - split-sync variant: separate sync in and out
// - twelve aux pins, independent direction and level
// - custom firmware reaches gpio via user registers
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "fpg_consts.svh"
module fpg_front_gpio
  import fpg_pkg::*;
#(
  parameter int NUM_AUX    = `FPG_NUM_AUX,  // aux connector pin count
  parameter bit SPLIT_SYNC = 1'b0           // sync uses separate in and out pins
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // connector pins, three signals each
  input  wire logic [`FPG_NUM_BITS-1:0] pin_in,
  output fpg_drive_t       pin_drive,
  // dedicated sync input/output on the split-sync variant
  input  wire logic        sync_split_in,
  output logic             sync_split_out,
  // toward the trigger logic and custom firmware
  output logic             ext_event_level,
  output logic             ext_sync_level,
  output fpg_pins_t        fw_pin_level,
  output logic [31:0]      fw_custom_ctrl,
  input  wire logic [31:0] fw_custom_stat
);

  localparam int NB = `FPG_NUM_BITS;

  fpg_pins_t     dir_q,   next_dir;          // 1 = output
  fpg_pins_t     level_q, next_level;        // output level
  logic [31:0]   custom_q, next_custom;      // software to firmware word
  fpg_pins_t     sync1_q, sync2_q;           // pin synchroniser stages
  logic          ss1_q, ss2_q;               // split-sync input synchroniser
  fpg_pins_t     sample;                     // level seen by the sampler
  fpg_wr_state_t wr_q,    next_wr;
  fpg_rd_state_t rd_q,    next_rd;
  logic          aw_have_q, next_aw_have;    // address latched
  logic          w_have_q,  next_w_have;     // data latched
  logic [11:0]   awaddr_q,  next_awaddr;
  logic [31:0]   wdata_q,   next_wdata;
  logic [3:0]    wstrb_q,   next_wstrb;
  logic [1:0]    bresp_q,   next_bresp;
  logic [31:0]   rdata_q,   next_rdata;
  logic [1:0]    rresp_q,   next_rresp;
  fpg_drive_t    drive_q,   next_drive;
  logic          sso_q,     next_sso;
  logic          evt_q,     ssy_q;
  fpg_pins_t     fwl_q;
  logic          awready_q, wready_q, bvalid_q, arready_q, rvalid_q;                // bus handshake flops
  logic          next_awready, next_wready, next_bvalid, next_arready, next_rvalid; // their next values

  // mask of pins that exist: event, sync (bidirectional unless split), aux
  function automatic fpg_pins_t pin_mask();
    fpg_pins_t m;
    m = '0;
    for (int i = 0; i < NB; i++) begin
      if (i == `FPG_BIT_EVENT) m[i] = 1'b1;
      else if (i == `FPG_BIT_SYNC) m[i] = 1'b1;
      else if (i - `FPG_BIT_AUX0 < NUM_AUX) m[i] = 1'b1;
    end
    return m;
  endfunction : pin_mask

  // merge a written word through byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // two-stage synchronisers on every incoming pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ss1_q   <= 1'b0;
      ss2_q   <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      ss1_q   <= sync_split_in;
      ss2_q   <= ss1_q;
    end
  end

  // sampler: pad level read on undriven pins; driven pins read their own level
  always_comb begin
    sample = sync2_q;
    for (int i = 0; i < NB; i++) begin
      if (dir_q[i]) sample[i] = level_q[i];
    end
    if (SPLIT_SYNC) sample[`FPG_BIT_SYNC] = ss2_q;
    sample = sample & pin_mask();
  end

  // write channel: accept address and data in either order, then respond
  always_comb begin
    next_wr      = wr_q;
    next_aw_have = aw_have_q;
    next_w_have  = w_have_q;
    next_awaddr  = awaddr_q;
    next_wdata   = wdata_q;
    next_wstrb   = wstrb_q;
    next_bresp   = bresp_q;
    next_dir     = dir_q;
    next_level   = level_q;
    next_custom  = custom_q;
    case (wr_q)
      FPG_WR_IDLE: begin
        if (s_axi_awvalid && !aw_have_q) begin
          next_aw_have = 1'b1;
          next_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
          next_w_have = 1'b1;
          next_wdata  = s_axi_wdata;
          next_wstrb  = s_axi_wstrb;
        end
        if (aw_have_q && w_have_q) begin
          next_bresp = `FPG_RESP_OKAY;
          case ({awaddr_q[11:2], 2'b00})
            `FPG_OFF_DIR:   next_dir    = fpg_pins_t'(merge(32'(dir_q), wdata_q, wstrb_q)) & pin_mask();
            `FPG_OFF_LEVEL: next_level  = fpg_pins_t'(merge(32'(level_q), wdata_q, wstrb_q)) & pin_mask();
            `FPG_OFF_CUSTOM_CTRL: next_custom = merge(custom_q, wdata_q, wstrb_q);
            `FPG_OFF_SAMPLE, `FPG_OFF_CUSTOM_STAT, `FPG_OFF_ROUTE: next_bresp = `FPG_RESP_OKAY;
            default:        next_bresp  = `FPG_RESP_SLVERR;
          endcase
          if (SPLIT_SYNC) next_dir[`FPG_BIT_SYNC] = 1'b0;
          next_aw_have = 1'b0;
          next_w_have  = 1'b0;
          next_wr      = FPG_WR_RESP;
        end
      end
      FPG_WR_RESP: begin
        if (s_axi_bready) next_wr = FPG_WR_IDLE;
      end
      default: next_wr = FPG_WR_IDLE;
    endcase
    // handshake outputs registered from the next state so the ports come from flops
    next_awready = (next_wr == FPG_WR_IDLE) && !next_aw_have;
    next_wready  = (next_wr == FPG_WR_IDLE) && !next_w_have;
    next_bvalid  = (next_wr == FPG_WR_RESP);
  end

  // read channel: one read at a time, data one cycle after the address
  always_comb begin
    next_rd    = rd_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    case (rd_q)
      FPG_RD_IDLE: begin
        if (s_axi_arvalid) begin
          next_rresp = `FPG_RESP_OKAY;
          next_rdata = '0;
          case ({s_axi_araddr[11:2], 2'b00})
            `FPG_OFF_DIR:         next_rdata = 32'(dir_q);
            `FPG_OFF_LEVEL:       next_rdata = 32'(level_q);
            `FPG_OFF_SAMPLE:      next_rdata = 32'(sample);
            `FPG_OFF_CUSTOM_CTRL: next_rdata = custom_q;
            `FPG_OFF_CUSTOM_STAT: next_rdata = fw_custom_stat;
            `FPG_OFF_ROUTE:       next_rdata = {31'h0000_0000, SPLIT_SYNC};
            default:              next_rresp = `FPG_RESP_SLVERR;
          endcase
          next_rd = FPG_RD_RESP;
        end
      end
      FPG_RD_RESP: begin
        if (s_axi_rready) next_rd = FPG_RD_IDLE;
      end
      default: next_rd = FPG_RD_IDLE;
    endcase
    // read handshake outputs follow the next read state
    next_arready = (next_rd == FPG_RD_IDLE);
    next_rvalid  = (next_rd == FPG_RD_RESP);
  end

  // pad drivers follow the direction and level registers one cycle later, through drive_q
  always_comb begin
    next_drive.oe  = dir_q & pin_mask();
    next_drive.out = level_q & dir_q;
    if (SPLIT_SYNC) begin
      next_drive.oe[`FPG_BIT_SYNC]  = 1'b0;
      next_drive.out[`FPG_BIT_SYNC] = 1'b0;
    end
    next_sso = SPLIT_SYNC ? level_q[`FPG_BIT_SYNC] : 1'b0;
  end

  // register every piece of state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q      <= FPG_WR_IDLE;
      rd_q      <= FPG_RD_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bresp_q   <= `FPG_RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `FPG_RESP_OKAY;
      dir_q     <= fpg_pins_t'(`FPG_RST_DIR);
      level_q   <= fpg_pins_t'(`FPG_RST_LEVEL);
      custom_q  <= `FPG_RST_CUSTOM;
      drive_q   <= '0;
      sso_q     <= 1'b0;
      evt_q     <= 1'b0;
      ssy_q     <= 1'b0;
      fwl_q     <= '0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end else begin
      wr_q      <= next_wr;
      rd_q      <= next_rd;
      aw_have_q <= next_aw_have;
      w_have_q  <= next_w_have;
      awaddr_q  <= next_awaddr;
      wdata_q   <= next_wdata;
      wstrb_q   <= next_wstrb;
      bresp_q   <= next_bresp;
      rdata_q   <= next_rdata;
      rresp_q   <= next_rresp;
      dir_q     <= next_dir;
      level_q   <= next_level;
      custom_q  <= next_custom;
      drive_q   <= next_drive;
      sso_q     <= next_sso;
      evt_q     <= sync2_q[`FPG_BIT_EVENT];  // pad level, even while driven
      ssy_q     <= SPLIT_SYNC ? ss2_q : sync2_q[`FPG_BIT_SYNC];
      fwl_q     <= sample;
      awready_q <= next_awready;
      wready_q  <= next_wready;
      bvalid_q  <= next_bvalid;
      arready_q <= next_arready;
      rvalid_q  <= next_rvalid;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready   = awready_q;
  assign s_axi_wready    = wready_q;
  assign s_axi_bvalid    = bvalid_q;
  assign s_axi_bresp     = bresp_q;
  assign s_axi_arready   = arready_q;
  assign s_axi_rvalid    = rvalid_q;
  assign s_axi_rdata     = rdata_q;
  assign s_axi_rresp     = rresp_q;
  assign pin_drive       = drive_q;
  assign sync_split_out  = sso_q;
  assign ext_event_level = evt_q;
  assign ext_sync_level  = ssy_q;
  assign fw_pin_level    = fwl_q;
  assign fw_custom_ctrl  = custom_q;

endmodule : fpg_front_gpio

// *** tb/fpg_front_gpio_props.sv ***
// fpg_front_gpio_props.sv: port checks on the gpio block
// assumes: bound into fpg_front_gpio, one clock
`timescale 1ns/1ps
module fpg_front_gpio_props
  import fpg_pkg::*;
#(
  parameter bit SPLIT_SYNC = 1'b0  // split sync pins
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire fpg_pins_t  pin_in,
  input wire fpg_drive_t pin_drive,
  input wire logic       sync_split_out,
  input wire logic       ext_event_level,
  input wire fpg_pins_t  fw_pin_level
);
  // one clock, quiet in reset
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address and data taken together
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> pin_drive == '0)
    else $error("pin driven after reset");
  a_out_gated: assert property ((pin_drive.out & ~pin_drive.oe) == '0)
    else $error("level on input pin");
  a_oe_by_write: assert property ($changed(pin_drive.oe) |-> $past(s_axi_bvalid))
    else $error("direction moved alone");
  a_event_seen: assert property ($rose(pin_in[0]) |-> ##[2:4] ext_event_level)
    else $error("event edge missed");
  a_input_seen: assert property (!pin_drive.oe[4] && $rose(pin_in[4]) |-> ##[2:4] fw_pin_level[4])
    else $error("input edge missed");
  a_output_read: assert property ($rose(pin_drive.oe[2]) |-> ##[1:4] (fw_pin_level[2] == pin_drive.out[2]))
    else $error("output reads wrong");
  a_split_sync: assert property (SPLIT_SYNC ? !pin_drive.oe[1] : !sync_split_out)
    else $error("sync misrouted");
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule : fpg_front_gpio_props

bind fpg_front_gpio fpg_front_gpio_props #(.SPLIT_SYNC(SPLIT_SYNC)) chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pin_in,
  .pin_drive, .sync_split_out, .ext_event_level, .fw_pin_level
);

// *** tb/fpg_equipment_model.sv ***
// fpg_equipment_model.sv: external gear on the pins
// assumes: bench sets the gear's levels
`timescale 1ns/1ps
module fpg_equipment_model
  import fpg_pkg::*;
(
  input  wire fpg_pins_t  drive_lvl,  // gear level
  input  wire fpg_drive_t pin_drive,  // device drivers
  output fpg_pins_t       pin_level   // wire level
);
  // a driven pin carries the device level, else the gear's
  assign pin_level = (pin_drive.oe & pin_drive.out) | (~pin_drive.oe & drive_lvl);
endmodule : fpg_equipment_model

// *** tb/fpg_front_gpio_tb.sv ***
// fpg_front_gpio_tb.sv: self-checking bench for the gpio block
// assumes: package, design, checker and gear model compiled first
`timescale 1ns/1ps
`include "fpg_consts.svh"
module fpg_front_gpio_tb
  import fpg_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, fw_custom_stat = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ext_event_level, ext_sync_level;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, rr;
  logic [31:0] s_axi_rdata, fw_custom_ctrl, v;
  fpg_pins_t   pin_in, fw_pin_level, want, ext_lvl = 14'h0000;
  fpg_drive_t  pin_drive;
  fpg_drive_t  sp_drive;                                     // split-sync instance drivers
  logic        sp_sync_in = 1'b0, sp_sync_out, sp_event, sp_sync; // split-sync pins
  int          n_fail = 0, check_count = 0, cycles = 0;
  fpg_pins_t   dir_tab [4] = '{14'h0001, 14'h3C06, 14'h3FFF, 14'h0000};
  fpg_pins_t   lvl_tab [4] = '{14'h0001, 14'h1409, 14'h2AAA, 14'h3FFF};

  fpg_front_gpio dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_drive,
    .sync_split_in(1'b0), .sync_split_out(), .ext_event_level, .ext_sync_level,
    .fw_pin_level, .fw_custom_ctrl, .fw_custom_stat
  );
  fpg_equipment_model eq_u (.drive_lvl(ext_lvl), .pin_drive, .pin_level(pin_in));
  // split-sync variant on the same bus and pads, answers follow dut_u cycle for cycle
  fpg_front_gpio #(.SPLIT_SYNC(1'b1)) dut_split_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .pin_in, .pin_drive(sp_drive),
    .sync_split_in(sp_sync_in), .sync_split_out(sp_sync_out), .ext_event_level(sp_event),
    .ext_sync_level(sp_sync), .fw_pin_level(), .fw_custom_ctrl(), .fw_custom_stat
  );

  // clock and hang guard
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // counts, verdict, end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // one write: both halves offered, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic pa = 1'b1;
    logic pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // one read
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FPG_OFF_DIR, v);
    chk(v, `FPG_RST_DIR);
    rd(`FPG_OFF_LEVEL, v);
    chk(v, `FPG_RST_LEVEL);
    chk({4'h0, pin_drive}, 32'h0);
    ext_lvl <= 14'h2A5C;
    sp_sync_in <= 1'b1;
    // direction, then level; gear holds the event pin low
    foreach (dir_tab[i]) begin
      wr(`FPG_OFF_DIR, {18'h0, dir_tab[i]}, r);
      wr(`FPG_OFF_LEVEL, {18'h0, lvl_tab[i]}, r);
      repeat (4) @(posedge aclk);
      want = (dir_tab[i] & lvl_tab[i]) | (~dir_tab[i] & ext_lvl);
      chk({4'h0, pin_drive}, {4'h0, dir_tab[i] & lvl_tab[i], dir_tab[i]});
      rd(`FPG_OFF_SAMPLE, v);
      chk(v, {18'h0, want});
      chk({18'h0, fw_pin_level}, {18'h0, want});
      chk({30'h0, ext_sync_level, ext_event_level}, {30'h0, want[1:0]});
      chk({4'h0, sp_drive}, {4'h0, dir_tab[i] & lvl_tab[i] & 14'h3FFD, dir_tab[i] & 14'h3FFD});
      chk({29'h0, sp_sync_out, sp_sync, sp_event}, {29'h0, lvl_tab[i][1], 1'b1, want[0]});
    end
    wr(`FPG_OFF_CUSTOM_CTRL, 32'hA5C3_0F12, r);
    chk(fw_custom_ctrl, 32'hA5C3_0F12);
    chk({30'h0, r}, {30'h0, `FPG_RESP_OKAY});
    fw_custom_stat <= 32'h5A3C_F0E1;
    rd(`FPG_OFF_CUSTOM_STAT, v);
    chk(v, 32'h5A3C_F0E1);
    rd(`FPG_OFF_ROUTE, v);
    chk(v, 32'h0);
    chk({30'h0, rr}, {30'h0, `FPG_RESP_OKAY});
    rd(12'h0FC, v);
    chk({30'h0, rr}, {30'h0, `FPG_RESP_SLVERR});
    wr(12'h0FC, 32'h1, r);
    chk({30'h0, r}, {30'h0, `FPG_RESP_SLVERR});
    tally_and_finish();
  end
endmodule : fpg_front_gpio_tb
